// ### src/hdf_pkg.sv
//****************************************************************************
// Purpose : Shared constants for the D-channel HDLC FIFO and event block.
// Assumes : Byte wide register port, 32 byte receive and transmit FIFOs.
// Notes   : Offsets, field positions and reset values live here only.
//****************************************************************************
package hdf_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned IDX_W      = 5;   // Index into one FIFO.
  localparam int unsigned PTR_W      = 6;   // Index plus wrap bit.

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADR_FIFO_LAST = 8'h1f;  // Window is 8'h00 to this.
  localparam logic [7:0] ADR_EVENT     = 8'h20;  // Read status, write mask.
  localparam logic [7:0] ADR_COMMAND   = 8'h21;
  localparam logic [7:0] ADR_MASK_RD   = 8'h22;
  localparam logic [7:0] ADR_EXT_ONE   = 8'h23;
  localparam logic [7:0] ADR_RBC_LOW   = 8'h25;
  localparam logic [7:0] ADR_RBC_HIGH  = 8'h26;
  localparam logic [7:0] ADR_RX_STAT   = 8'h27;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned EV_RME = 7;
  localparam int unsigned EV_RPF = 6;
  localparam int unsigned EV_RFO = 5;
  localparam int unsigned EV_XPR = 4;
  localparam int unsigned EV_XMR = 3;
  localparam int unsigned EV_XDU = 2;
  localparam int unsigned CMD_RMC  = 7;
  localparam int unsigned CMD_XTF  = 3;
  localparam int unsigned CMD_XME  = 1;
  localparam int unsigned CMD_TX_RESET_CMD = 0;
  localparam int unsigned EXT_TX_BLOCK_SIZE   = 7;   // 0: 32 byte, 1: 16 byte.
  localparam int unsigned EXT_RX_BLOCK_SIZE_H = 6;   // Two bit receive block size.
  localparam int unsigned EXT_RX_BLOCK_SIZE_L = 5;

  // ****************************************************************
  // Reset values and counts
  // ****************************************************************
  localparam logic [7:0] EVENT_RST   = 8'h10;
  localparam logic [7:0] MASK_RST    = 8'hff;
  localparam logic [7:0] EXT_ONE_RST = 8'h00;
  localparam logic [7:0] EVENT_BITS  = 8'hfc;  // Bits 1 and 0 read zero.
  localparam logic [2:0] ABORT_ONES  = 3'h7;

  // Receive block size in bytes from the two bit setting.
  function automatic logic [PTR_W-1:0] hdf_rx_block(input logic [1:0] sel);
    case (sel)
      2'h0:    hdf_rx_block = 6'h20;
      2'h1:    hdf_rx_block = 6'h10;
      2'h2:    hdf_rx_block = 6'h08;
      default: hdf_rx_block = 6'h04;
    endcase
  endfunction : hdf_rx_block

  // Transmit block size in bytes from the one bit setting.
  function automatic logic [PTR_W-1:0] hdf_tx_block(input logic sel);
    hdf_tx_block = sel ? 6'h10 : 6'h20;
  endfunction : hdf_tx_block

endpackage : hdf_pkg

// ### src/hdf_mem.sv
//****************************************************************************
// Purpose : 32 by 8 FIFO storage with one write and one read port.
// Assumes : Single clock; read data registered.
// Notes   : Read data change only on a read enable.
//****************************************************************************
`timescale 1ns/10ps
module hdf_mem
  import hdf_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             wr_en,
  input  wire logic [IDX_W-1:0] wr_addr,
  input  wire logic [7:0]       wr_data,
  input  wire logic             rd_en,
  input  wire logic [IDX_W-1:0] rd_addr,
  output logic      [7:0]       rd_data
);

  logic [7:0] store [FIFO_DEPTH];

  // Storage has no reset; the pointers decide what is valid.
  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      store[wr_addr] <= wr_data;
    end
    if (rd_en)
    begin
      rd_data <= store[rd_addr];
    end
  end

endmodule : hdf_mem

// ### src/hdf_abort.sv
//****************************************************************************
// Purpose : Sends the abort sequence of seven ones onto the line.
// Assumes : One line bit per clock while active.
// Notes   : A new start during a sequence restarts the count.
//****************************************************************************
`timescale 1ns/10ps
module hdf_abort
  import hdf_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic start,
  output logic      abort_active,
  output logic      abort_bit
);

  logic [2:0] left;

  // Count down the ones still to send.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      left <= 3'h0;
    end
    else if (start)
    begin
      left <= ABORT_ONES;
    end
    else if (left != 3'h0)
    begin
      left <= left - 3'h1;
    end
  end

  assign abort_active = (left != 3'h0);
  assign abort_bit    = abort_active;

endmodule : hdf_abort

// ### src/hdf_ctrl.sv
//****************************************************************************
// Purpose : Host FIFO windows and event flags of a D-channel HDLC controller.
// Assumes : Line engine runs on ref_clk; host uses the plain register port.
// Notes   : Read data appear in the cycle after the read strobe only.
//****************************************************************************
`timescale 1ns/10ps
module hdf_ctrl
  import hdf_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             dchan_irq,
  input  wire logic        line_rx_valid,
  input  wire logic [7:0]  line_rx_data,
  input  wire logic        line_rx_end,
  input  wire logic [7:0]  line_rx_status,
  input  wire logic        line_tx_take,
  output logic      [7:0]  line_tx_data,
  output logic             line_tx_valid,
  output logic             line_tx_last,
  input  wire logic        line_tx_done,
  input  wire logic        line_collision,
  output logic             line_abort_active,
  output logic             line_abort_bit
);

  // ****************************************************************
  // Register port decode
  // ****************************************************************
  logic [7:0]       event_status;
  logic [7:0]       dchan_event_mask;
  logic [7:0]       ext_mode_one;
  logic [11:0]      rx_byte_count;
  logic [7:0]       rx_frame_status;
  logic             fifo_read_q;
  logic [7:0]       reg_q;
  logic [7:0]       rx_mem_q;
  logic             tx_lock_mr;
  logic             tx_lock_du;

  // Decoding as named wires; unmapped addresses read zero, writes drop.
  wire in_window  = (reg_addr <= ADR_FIFO_LAST);
  wire host_rx_rd = reg_rd & in_window;
  wire ev_rd      = reg_rd & (reg_addr == ADR_EVENT);
  wire mask_wr    = reg_wr & (reg_addr == ADR_EVENT);
  wire cmd_wr     = reg_wr & (reg_addr == ADR_COMMAND);
  wire ext_wr     = reg_wr & (reg_addr == ADR_EXT_ONE);
  wire tx_locked  = tx_lock_mr | tx_lock_du;
  wire cmd_rmc    = cmd_wr & reg_wdata[CMD_RMC];
  wire cmd_tx_reset_cmd   = cmd_wr & reg_wdata[CMD_TX_RESET_CMD];
  wire cmd_xtf    = cmd_wr & reg_wdata[CMD_XTF] & ~cmd_tx_reset_cmd & ~tx_locked;
  wire cmd_xme    = cmd_wr & reg_wdata[CMD_XME] & ~cmd_tx_reset_cmd & ~tx_locked;
  wire [7:0] visible = event_status & ~dchan_event_mask & EVENT_BITS;

  // Register read selection.
  logic [7:0] read_mux;
  always_comb
  begin
    if (reg_addr == ADR_EVENT)
      read_mux = visible;
    else if (reg_addr == ADR_MASK_RD)
      read_mux = dchan_event_mask;
    else if (reg_addr == ADR_EXT_ONE)
      read_mux = ext_mode_one;
    else if (reg_addr == ADR_RBC_LOW)
      read_mux = rx_byte_count[7:0];
    else if (reg_addr == ADR_RBC_HIGH)
      read_mux = {4'h0, rx_byte_count[11:8]};
    else if (reg_addr == ADR_RX_STAT)
      read_mux = rx_frame_status;
    else
      read_mux = 8'h00;
  end

  // Read data stand one cycle; FIFO data come from the memory register.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      fifo_read_q <= 1'b0;
      reg_q       <= 8'h00;
    end
    else
    begin
      fifo_read_q <= host_rx_rd;
      reg_q       <= reg_rd ? read_mux : 8'h00;
    end
  end

  assign reg_rdata = fifo_read_q ? rx_mem_q : reg_q;

  // Mask and mode registers written by software.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      dchan_event_mask <= MASK_RST;
      ext_mode_one     <= EXT_ONE_RST;
    end
    else
    begin
      if (mask_wr)
        dchan_event_mask <= reg_wdata;
      if (ext_wr)
        ext_mode_one <= reg_wdata;
    end
  end

  // ****************************************************************
  // Receive side
  // ****************************************************************
  logic [PTR_W-1:0] rx_wp;
  logic [PTR_W-1:0] rx_rp;
  logic [PTR_W-1:0] rx_base;
  logic [PTR_W-1:0] rx_fstart;
  logic [PTR_W-1:0] rx_blk;
  logic [11:0]      rx_len;
  logic             rx_drop;

  wire [PTR_W-1:0] rx_size  = hdf_rx_block(ext_mode_one[EXT_RX_BLOCK_SIZE_H:EXT_RX_BLOCK_SIZE_L]);
  wire [PTR_W-1:0] rx_used  = rx_wp - rx_base;
  wire             rx_full  = rx_used[PTR_W-1];
  wire             rx_store = line_rx_valid & ~rx_drop & ~rx_full;
  wire             rx_ovf   = line_rx_valid & ~rx_drop & rx_full;
  wire             rx_bhit  = (rx_blk + 6'h01) == rx_size;
  wire             rx_pf    = rx_store & ~line_rx_end & rx_bhit;
  wire             rx_me    = rx_store & line_rx_end;
  wire [PTR_W-1:0] rx_wp_nx = rx_wp + 6'h01;

  // Pointers: once one byte finds no room, its unannounced bytes are thrown away and the rest of the message dropped.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rx_wp     <= '0;
      rx_rp     <= '0;
      rx_base   <= '0;
      rx_fstart <= '0;
      rx_blk    <= '0;
      rx_len    <= 12'h000;
      rx_drop   <= 1'b0;
    end
    else
    begin
      if (host_rx_rd)
        rx_rp <= rx_rp + 6'h01;
      if (cmd_rmc)
        rx_base <= rx_rp;          // Space the host has read is released.
      if (rx_ovf)
      begin
        rx_wp   <= rx_fstart;
        rx_blk  <= '0;
        rx_len  <= 12'h000;
        rx_drop <= ~line_rx_end;
      end
      else if (line_rx_valid & rx_drop & line_rx_end)
        rx_drop <= 1'b0;
      else if (rx_store)
      begin
        rx_wp  <= rx_wp_nx;
        rx_blk <= (rx_bhit | line_rx_end) ? '0 : rx_blk + 6'h01;
        rx_len <= line_rx_end ? 12'h000 : rx_len + 12'h001;
        if (rx_pf | rx_me)
          rx_fstart <= rx_wp_nx;   // Announced blocks cannot be taken back.
      end
    end
  end

  // Frame length and status are captured at frame end.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      rx_byte_count   <= 12'h000;
      rx_frame_status <= 8'h00;
    end
    else if (rx_me)
    begin
      rx_byte_count   <= rx_len + 12'h001;
      rx_frame_status <= line_rx_status;
    end
  end

  hdf_mem u_rx_mem (
    .ref_clk (ref_clk),
    .wr_en   (rx_store),
    .wr_addr (rx_wp[IDX_W-1:0]),
    .wr_data (line_rx_data),
    .rd_en   (host_rx_rd),
    .rd_addr (rx_rp[IDX_W-1:0]),
    .rd_data (rx_mem_q)
  );

  // ****************************************************************
  // Transmit side
  // ****************************************************************
  logic [PTR_W-1:0] tx_wp;
  logic [PTR_W-1:0] tx_rp;
  logic [PTR_W-1:0] tx_fstart;
  logic [PTR_W-1:0] tx_sent;
  logic             tx_active;
  logic             tx_end_given;
  logic             tx_wait_xpr;
  logic             tx_wait_done;

  wire [PTR_W-1:0] tx_size   = hdf_tx_block(ext_mode_one[EXT_TX_BLOCK_SIZE]);
  wire [PTR_W-1:0] tx_used   = tx_wp - tx_rp;
  wire [PTR_W-1:0] tx_free   = 6'h20 - tx_used;
  wire             host_tx_wr = reg_wr & in_window & ~tx_locked & ~tx_used[PTR_W-1];
  wire             tx_give   = line_tx_take & tx_active & (tx_used != 6'h00);
  wire             tx_under  = line_tx_take & tx_active & (tx_used == 6'h00)
                               & ~tx_end_given;
  wire             tx_late   = line_collision & tx_active & (tx_sent >= tx_size);
  wire             tx_early  = line_collision & tx_active & ~tx_late;
  wire             tx_flush  = cmd_tx_reset_cmd | tx_under | tx_late;
  wire             xpr_space = tx_wait_xpr & (tx_free >= tx_size);
  wire             xpr_sent  = tx_wait_done & line_tx_done;
  wire             xpr_set   = xpr_space | xpr_sent | cmd_tx_reset_cmd;
  wire             xmr_seen  = ev_rd & visible[EV_XMR];
  wire             xdu_seen  = ev_rd & visible[EV_XDU];

  // Frame control: commands, line requests and collisions.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tx_wp        <= '0;
      tx_rp        <= '0;
      tx_fstart    <= '0;
      tx_sent      <= '0;
      tx_active    <= 1'b0;
      tx_end_given <= 1'b0;
      tx_wait_xpr  <= 1'b0;
      tx_wait_done <= 1'b0;
    end
    else if (tx_flush)
    begin
      tx_wp        <= '0;
      tx_rp        <= '0;
      tx_fstart    <= '0;
      tx_sent      <= '0;
      tx_active    <= 1'b0;
      tx_end_given <= 1'b0;
      tx_wait_xpr  <= 1'b0;
      tx_wait_done <= 1'b0;
    end
    else
    begin
      if (host_tx_wr)
        tx_wp <= tx_wp + 6'h01;
      if (tx_early)
      begin
        tx_rp   <= tx_fstart;  // Early collision: resend from frame start.
        tx_sent <= '0;
      end
      else if (tx_give)
      begin
        tx_rp   <= tx_rp + 6'h01;
        tx_sent <= (tx_sent == 6'h3f) ? tx_sent : tx_sent + 6'h01;
      end
      if ((cmd_xtf | cmd_xme) & ~tx_active)
      begin
        tx_fstart <= tx_rp;
        tx_sent   <= '0;
      end
      if (cmd_xtf | cmd_xme)
      begin
        tx_active    <= 1'b1;
        tx_end_given <= cmd_xme;
        tx_wait_xpr  <= ~cmd_xme;
        tx_wait_done <= cmd_xme;
      end
      else
      begin
        if (xpr_space)
          tx_wait_xpr <= 1'b0;
        if (line_tx_done)
        begin
          tx_active    <= 1'b0;
          tx_wait_done <= 1'b0;
        end
      end
    end
  end

  // Locks hold the window shut until the host has read the bit.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      tx_lock_mr <= 1'b0;
      tx_lock_du <= 1'b0;
    end
    else
    begin
      tx_lock_mr <= tx_late | (tx_lock_mr & ~xmr_seen);
      tx_lock_du <= tx_under | (tx_lock_du & ~xdu_seen);
    end
  end

  // Line answer: data valid one cycle after the take.
  logic [7:0] tx_mem_q;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      line_tx_valid <= 1'b0;
      line_tx_last  <= 1'b0;
    end
    else
    begin
      line_tx_valid <= tx_give;
      line_tx_last  <= tx_give & tx_end_given & (tx_used == 6'h01);
    end
  end

  assign line_tx_data = tx_mem_q;

  hdf_mem u_tx_mem (
    .ref_clk (ref_clk),
    .wr_en   (host_tx_wr),
    .wr_addr (tx_wp[IDX_W-1:0]),
    .wr_data (reg_wdata),
    .rd_en   (tx_give),
    .rd_addr (tx_rp[IDX_W-1:0]),
    .rd_data (tx_mem_q)
  );

  // Abort sequence on underrun or on a reset of a running frame.
  hdf_abort u_abort (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .start        (tx_under | (cmd_tx_reset_cmd & tx_active)),
    .abort_active (line_abort_active),
    .abort_bit    (line_abort_bit)
  );

  // ****************************************************************
  // Event status
  // ****************************************************************
  logic [7:0] ev_set;
  always_comb
  begin
    ev_set         = 8'h00;
    ev_set[EV_RME] = rx_me;
    ev_set[EV_RPF] = rx_pf;
    ev_set[EV_RFO] = rx_ovf;
    ev_set[EV_XPR] = xpr_set;
    ev_set[EV_XMR] = tx_late;
    ev_set[EV_XDU] = tx_under;
  end

  // A set in the same cycle as a clearing read wins.
  wire [7:0] ev_clr       = ev_rd ? visible : 8'h00;
  wire [7:0] next_status  = ((event_status & ~ev_clr) | ev_set) & EVENT_BITS;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      event_status <= EVENT_RST;
    else
      event_status <= next_status;
  end

  assign dchan_irq = |visible;

endmodule : hdf_ctrl

// ### bench/hdf_ctrl_chk.sv
// Purpose : Port checker for hdf_ctrl.
// Assumes : One clock, synchronous active high reset.
// Notes   : Bound to every hdf_ctrl instance at the foot of this file.
`timescale 1ns/10ps
module hdf_ctrl_chk
  import hdf_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       dchan_irq,
  input wire logic       line_tx_take,
  input wire logic       line_tx_valid,
  input wire logic       line_tx_last,
  input wire logic       line_abort_active,
  input wire logic       line_abort_bit
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  logic tx_reset_cmd_q;
  logic take_q;

  // Causes of an abort, held one cycle so the start may lag by one or two.
  always_ff @(posedge ref_clk)
  begin
    tx_reset_cmd_q <= reg_wr && (reg_addr == ADR_COMMAND) && reg_wdata[CMD_TX_RESET_CMD];
    take_q <= line_tx_take;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  AST_EVENT_ZERO: assert property ($past(reg_rd) && $past(reg_addr) == ADR_EVENT
    |-> reg_rdata[1:0] == 2'h0) else $error("event status low bits not zero");
  AST_ABORT_LEN: assert property ($rose(line_abort_active)
    |-> line_abort_active [*7] ##1 !line_abort_active) else $error("abort not seven cycles");
  AST_ABORT_BIT: assert property (line_abort_bit == line_abort_active)
    else $error("abort bit not one during abort");
  AST_ABORT_CAUSE: assert property ($rose(line_abort_active)
    |-> take_q || $past(take_q) || tx_reset_cmd_q || $past(tx_reset_cmd_q)) else $error("abort without cause");
  AST_TX_ANSWER: assert property (line_tx_valid |-> take_q)
    else $error("transmit byte without take");
  AST_TX_LAST: assert property (line_tx_last |-> line_tx_valid)
    else $error("last flag without byte");
  AST_RESET_QUIET: assert property ($fell(reset)
    |-> !dchan_irq && !line_tx_valid && !line_abort_active) else $error("noisy after reset");

  COV_ABORT: cover property ($rose(line_abort_active));
  COV_LAST: cover property (line_tx_valid && line_tx_last);
  COV_IRQ: cover property ($fell(dchan_irq));
endmodule : hdf_ctrl_chk

bind hdf_ctrl hdf_ctrl_chk u_chk (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .dchan_irq(dchan_irq), .line_tx_take(line_tx_take), .line_tx_valid(line_tx_valid),
  .line_tx_last(line_tx_last), .line_abort_active(line_abort_active),
  .line_abort_bit(line_abort_bit));

// ### bench/hdf_line_model.sv
// Purpose : Behavioural line engine facing the FIFO block.
// Assumes : Driven by tasks from the bench, one byte per call.
// Notes   : Released data lines show the inverse, never a stale byte.
`timescale 1ns/10ps
module hdf_line_model
(
  input  wire logic       ref_clk,
  output logic            line_rx_valid,
  output logic [7:0]      line_rx_data,
  output logic            line_rx_end,
  output logic [7:0]      line_rx_status,
  output logic            line_tx_take,
  input  wire logic [7:0] line_tx_data,
  input  wire logic       line_tx_valid,
  input  wire logic       line_tx_last,
  output logic            line_tx_done,
  output logic            line_collision
);
  // Quiet lines at time zero.
  initial
  begin
    {line_rx_valid, line_rx_end, line_tx_take, line_tx_done, line_collision} = 5'h00;
    line_rx_data = 8'h00;
    line_rx_status = 8'h00;
  end

  // One received byte after an idle gap, so both fast and slow lines occur.
  task automatic rx_byte(input logic [7:0] d, input logic e, input logic [7:0] st, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    line_rx_valid <= 1'b1;
    line_rx_data <= d;
    line_rx_end <= e;
    line_rx_status <= st;
    @(posedge ref_clk);
    line_rx_valid <= 1'b0;
    line_rx_data <= ~d;
    line_rx_end <= 1'b0;
  endtask : rx_byte

  // Ask for a byte; the answer stands one cycle after the take.
  task automatic take(output logic v, output logic [7:0] d, output logic l);
    @(posedge ref_clk);
    line_tx_take <= 1'b1;
    @(posedge ref_clk);
    line_tx_take <= 1'b0;
    #1;
    v = line_tx_valid;
    d = line_tx_data;
    l = line_tx_last;
  endtask : take

  // Closing flag sent, or collision seen, for one cycle.
  task automatic pulse(input logic coll);
    @(posedge ref_clk);
    if (coll) line_collision <= 1'b1;
    else line_tx_done <= 1'b1;
    @(posedge ref_clk);
    line_collision <= 1'b0;
    line_tx_done <= 1'b0;
  endtask : pulse
endmodule : hdf_line_model

// ### bench/dchan_hdlc_fifo_irq_test.sv
// Purpose : Self-checking bench for hdf_ctrl.
// Assumes : Host strobes are driven by the bench after rising edges.
// Notes   : Each section starts from a fresh reset where state would leak.
`timescale 1ns/10ps
`define HDF_CMP(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("mismatch at %0t got %h exp %h", $time, got, exp); \
    end \
  end
module dchan_hdlc_fifo_irq_test
  import hdf_pkg::*;
;
  logic       ref_clk;
  logic       reset;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       dchan_irq;
  logic       rx_valid, rx_end, tx_take, tx_valid, tx_last, tx_done, coll;
  logic       abort_act, abort_bit;
  logic [7:0] rx_data, rx_status, tx_data;
  int         failures;
  int         n_compared;

  hdf_ctrl dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dchan_irq(dchan_irq), .line_rx_valid(rx_valid), .line_rx_data(rx_data),
    .line_rx_end(rx_end), .line_rx_status(rx_status), .line_tx_take(tx_take),
    .line_tx_data(tx_data), .line_tx_valid(tx_valid), .line_tx_last(tx_last),
    .line_tx_done(tx_done), .line_collision(coll), .line_abort_active(abort_act),
    .line_abort_bit(abort_bit));
  hdf_line_model u_line (.ref_clk(ref_clk), .line_rx_valid(rx_valid), .line_rx_data(rx_data),
    .line_rx_end(rx_end), .line_rx_status(rx_status), .line_tx_take(tx_take),
    .line_tx_data(tx_data), .line_tx_valid(tx_valid), .line_tx_last(tx_last),
    .line_tx_done(tx_done), .line_collision(coll));

  // Free running 50 MHz clock.
  always #10 ref_clk = ~ref_clk;

  // ****************************************************************
  // Host tasks
  // ****************************************************************
  task automatic finish_test;
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic rd_cmp(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    `HDF_CMP(d, exp)
  endtask : rd_cmp

  task automatic tx_cmp(input logic v, input logic [7:0] d, input logic l);
    logic       gv;
    logic       gl;
    logic [7:0] gd;
    u_line.take(gv, gd, gl);
    `HDF_CMP(gv, v)
    if (v)
    begin
      `HDF_CMP(gd, d)
      `HDF_CMP(gl, l)
    end
  endtask : tx_cmp

  // Reset, unmask all, set block sizes, drop the pool ready from reset.
  task automatic setup(input logic [7:0] ext);
    logic [7:0] d;
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    wr(ADR_EVENT, 8'h00);
    wr(ADR_EXT_ONE, ext);
    rd(ADR_EVENT, d);
  endtask : setup

  // A locked FIFO ignores data and the XTF and XME commands until the event bit is read; a transmitter reset still acts.
  task automatic lock_probe(input int bitpos);
    logic [7:0] d;
    wr(8'h00, 8'haa);
    wr(ADR_COMMAND, 8'h0a);
    tx_cmp(1'b0, 8'h00, 1'b0);
    rd(ADR_EVENT, d);
    `HDF_CMP(d[bitpos], 1'b1)
    wr(8'h00, 8'h5a);
    wr(ADR_COMMAND, 8'h0a);
    tx_cmp(1'b1, 8'h5a, 1'b1);
    u_line.pulse(1'b0);
  endtask : lock_probe

  // Hang guard.
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    finish_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    logic [3:0] n;
    ref_clk = 1'b0;
    reset = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
    failures = 0;
    n_compared = 0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    wr(ADR_EVENT, 8'h00);
    rd_cmp(ADR_EVENT, 8'h10);
    rd_cmp(ADR_EVENT, 8'h00);
    rd_cmp(8'h30, 8'h00);
    wr(ADR_EVENT, 8'hff);
    rd_cmp(ADR_MASK_RD, 8'hff);
    wr(ADR_COMMAND, 8'h01);
    rd_cmp(ADR_EVENT, 8'h00);
    `HDF_CMP(dchan_irq, 1'b0)
    wr(ADR_EVENT, 8'h00);
    #1;
    `HDF_CMP(dchan_irq, 1'b1)
    rd_cmp(ADR_EVENT, 8'h10);
    `HDF_CMP(dchan_irq, 1'b0)
    // Receive: short frame, then a longer one, in four byte blocks.
    wr(ADR_EXT_ONE, 8'h60);
    for (int i = 0; i < 3; i++) u_line.rx_byte(8'h30 + 8'(i), i == 2, 8'h5c, i);
    rd_cmp(ADR_EVENT, 8'h80);
    rd_cmp(ADR_RBC_LOW, 8'h03);
    rd_cmp(ADR_RX_STAT, 8'h5c);
    for (int i = 0; i < 3; i++) rd_cmp(8'(i * 11), 8'h30 + 8'(i));
    wr(ADR_COMMAND, 8'h80);
    for (int i = 0; i < 6; i++)
    begin
      u_line.rx_byte(8'h40 + 8'(i), i == 5, 8'h21, 0);
      if (i == 3) rd_cmp(ADR_EVENT, 8'h40);
    end
    rd_cmp(ADR_EVENT, 8'h80);
    rd_cmp(ADR_RBC_LOW, 8'h06);
    for (int i = 0; i < 6; i++) rd_cmp(8'h1f, 8'h40 + 8'(i));
    wr(ADR_COMMAND, 8'h80);
    // Overflow: a frame longer than the whole FIFO.
    setup(8'h00);
    for (int i = 0; i < 40; i++) u_line.rx_byte(8'(i), i == 39, 8'h00, 0);
    rd_cmp(ADR_EVENT, 8'h60);
    for (int i = 0; i < 32; i++) rd_cmp(8'h00, 8'(i));
    // Block sizes of 16 and 8 bytes: pool full on a block, then message end.
    for (int s = 1; s < 3; s++)
    begin
      setup(8'(s * 32));
      for (int i = 0; i <= (32 >> s); i++) u_line.rx_byte(8'(i), i == (32 >> s), 8'h00, 0);
      rd_cmp(ADR_EVENT, 8'hc0);
      rd_cmp(ADR_RBC_LOW, 8'((32 >> s) + 1));
    end
    // Transmit a short complete frame.
    setup(8'h80);
    for (int i = 0; i < 3; i++) wr(8'(i * 9), 8'ha0 + 8'(i));
    wr(ADR_COMMAND, 8'h0a);
    for (int i = 0; i < 3; i++) tx_cmp(1'b1, 8'ha0 + 8'(i), i == 2);
    rd_cmp(ADR_EVENT, 8'h00);
    u_line.pulse(1'b0);
    rd_cmp(ADR_EVENT, 8'h10);
    // Underrun in an unfinished frame.
    wr(8'h00, 8'h11);
    wr(8'h01, 8'h12);
    wr(ADR_COMMAND, 8'h08);
    rd_cmp(ADR_EVENT, 8'h10);
    tx_cmp(1'b1, 8'h11, 1'b0);
    tx_cmp(1'b1, 8'h12, 1'b0);
    tx_cmp(1'b0, 8'h00, 1'b0);
    n = {3'h0, abort_bit};
    repeat (12)
    begin
      @(posedge ref_clk);
      #1;
      n += {3'h0, abort_bit};
    end
    `HDF_CMP(n, 4'h7)
    `HDF_CMP(abort_act, 1'b0)
    lock_probe(EV_XDU);
    // Late collision after one full block.
    setup(8'h80);
    for (int i = 0; i < 16; i++) wr(8'h00, 8'(i));
    wr(ADR_COMMAND, 8'h08);
    for (int i = 0; i < 16; i++) tx_cmp(1'b1, 8'(i), 1'b0);
    u_line.pulse(1'b1);
    lock_probe(EV_XMR);
    // Transmitter reset in mid frame.
    setup(8'h80);
    wr(8'h00, 8'h77);
    wr(8'h00, 8'h78);
    wr(ADR_COMMAND, 8'h08);
    tx_cmp(1'b1, 8'h77, 1'b0);
    wr(ADR_COMMAND, 8'h01);
    tx_cmp(1'b0, 8'h00, 1'b0);
    finish_test();
  end
endmodule : dchan_hdlc_fifo_irq_test
